// file: bench/asr_host_tb.sv
// Self-checking testbench for the SRAM host controller
`timescale 1ns/100ps
module asr_host_tb;
  import asr_pkg::*;
  logic clk = 0, reset = 1, reqValid = 0, reqWrite = 0, retainReq = 0;
  logic reqReady, rspValid, retaining, chipSel_n, writeStrobe_n, outGate_n;
  logic low_byte_sel_n, high_byte_sel_n;
  logic [1:0] reqByteEn = 2'h0;
  logic [17:0] reqAddr = 18'h0, word_address;
  logic [15:0] reqWdata = 16'h0, rspRdata, rd;
  logic [15:0] shared_data_lines_in, shared_data_lines_out, shared_data_lines_oe_n;
  int fail_count = 0, check_count = 0, n, lowCyc;
  always #12.5 clk = ~clk;
  asr_host #(.REC_CYC(8)) uut (.clk, .reset, .reqValid, .reqWrite, .reqAddr, .reqWdata,
    .reqByteEn, .retainReq, .reqReady, .rspValid, .rspRdata, .retaining, .word_address,
    .chipSel_n, .writeStrobe_n, .outGate_n, .low_byte_sel_n, .high_byte_sel_n,
    .shared_data_lines_in, .shared_data_lines_out, .shared_data_lines_oe_n);
  asr_sram_model sram (.word_address, .chipSel_n, .writeStrobe_n, .outGate_n,
    .low_byte_sel_n, .high_byte_sel_n, .shared_data_lines_out, .shared_data_lines_oe_n,
    .shared_data_lines_in);
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clk) if (!outGate_n && !chipSel_n) check("host release", shared_data_lines_oe_n, 16'hFFFF);
  task automatic access(logic wr, logic [17:0] a, logic [15:0] d, logic [1:0] be);
    while (reqReady !== 1'b1) @(negedge clk);
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqWdata <= d;
    reqByteEn <= be;
    @(posedge clk);
    reqValid <= 1'b0;
    n = 0;
    lowCyc = 0;
    while (rspValid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
      lowCyc += (writeStrobe_n === 1'b0);
      if (wr && !chipSel_n) check("gate in write", outGate_n, 1'b1);
    end
    check("latency", n, wr ? 3 : 4);
    check("strobe cycles", lowCyc >= WP_CYC, wr);
    rd = rspRdata;
  endtask
  task automatic rdx(logic [17:0] a, logic [1:0] be, logic [15:0] m, logic [15:0] e);
    access(1'b0, a, 16'h0000, be);
    check("read data", rd & m, e);
  endtask
  task automatic t_full();
    access(1'b1, 18'h3FFFF, 16'hBEEF, 2'h3);
    access(1'b1, 18'h00000, 16'h1234, 2'h3);
    rdx(18'h3FFFF, 2'h3, 16'hFFFF, 16'hBEEF);
    rdx(18'h00000, 2'h3, 16'hFFFF, 16'h1234);
    $display("test full word done");
  endtask
  task automatic t_lanes();
    access(1'b1, 18'h00005, 16'hA1B2, 2'h3);
    access(1'b1, 18'h00005, 16'h77C3, 2'h1);
    rdx(18'h00005, 2'h3, 16'hFFFF, 16'hA1C3);
    access(1'b1, 18'h00005, 16'hD499, 2'h2);
    rdx(18'h00005, 2'h3, 16'hFFFF, 16'hD4C3);
    rdx(18'h00005, 2'h1, 16'h00FF, 16'h00C3);
    rdx(18'h00005, 2'h2, 16'hFF00, 16'hD400);
    $display("test byte lanes done");
  endtask
  task automatic t_noen();
    @(posedge clk);
    reqValid <= 1'b1;
    reqByteEn <= 2'h0;
    repeat (8) begin
      @(negedge clk);
      check("no select", {chipSel_n, rspValid}, 2'b10);
    end
    @(posedge clk);
    reqValid <= 1'b0;
    $display("test empty lanes done");
  endtask
  task automatic t_retain();
    @(posedge clk);
    retainReq <= 1'b1;
    repeat (4) @(negedge clk);
    check("retain", {chipSel_n, retaining}, 2'b11);
    @(posedge clk);
    retainReq <= 1'b0;
    n = 0;
    while (retaining === 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
      if (retaining === 1'b1) check("held off", chipSel_n, 1'b1);
    end
    check("recovery", n >= 8 && n < 50, 1'b1);
    access(1'b1, 18'h00009, 16'h5A5A, 2'h3);
    rdx(18'h00009, 2'h3, 16'hFFFF, 16'h5A5A);
    $display("test retention done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_full();
    t_lanes();
    t_noen();
    t_retain();
    close_out();
  end
  initial begin
    #(3000 * 25);
    fail_count++;
    close_out();
  end
endmodule

// file: bench/asr_sram_model.sv
// Behavioural model of the 256K x 16 asynchronous static RAM
`timescale 1ns/100ps
module asr_sram_model (
  // Memory pins
  input wire logic [17:0] word_address,
  input wire logic chipSel_n,
  input wire logic writeStrobe_n,
  input wire logic outGate_n,
  input wire logic low_byte_sel_n,
  input wire logic high_byte_sel_n,
  // Host side of the data lines
  input wire logic [15:0] shared_data_lines_out,
  input wire logic [15:0] shared_data_lines_oe_n,
  // Resolved data lines
  output logic [15:0] shared_data_lines_in
);
  logic [15:0] mem [0:262143];
  logic [15:0] filler = 16'hA5C3;
  logic [15:0] rdWord;
  logic [1:0] rdLane;
  wire logic rdOn = !chipSel_n && writeStrobe_n && !outGate_n;
  // Released lines wander
  always #13 filler = ~filler;
  assign #20 rdWord = mem[word_address];
  assign rdLane = {2{rdOn}} & ~{high_byte_sel_n, low_byte_sel_n};
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!shared_data_lines_oe_n[i] && rdLane[i/8]) shared_data_lines_in[i] = 1'bx;
      else if (!shared_data_lines_oe_n[i]) shared_data_lines_in[i] = shared_data_lines_out[i];
      else if (rdLane[i/8]) shared_data_lines_in[i] = rdWord[i];
      else shared_data_lines_in[i] = filler[i];
    end
  end
  always @* begin
    if (!chipSel_n && !writeStrobe_n) begin
      if (!low_byte_sel_n) mem[word_address][7:0] = shared_data_lines_in[7:0];
      if (!high_byte_sel_n) mem[word_address][15:8] = shared_data_lines_in[15:8];
    end
  end
endmodule

// file: logic/asr_host.sv
// Host controller driving an asynchronous 256K x 16 static RAM
`timescale 1ns/100ps
module asr_host #(
  parameter int REC_CYC = asr_pkg::REC_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // User request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [asr_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [asr_pkg::DATA_W-1:0] reqWdata,
  input wire logic [1:0] reqByteEn,
  input wire logic retainReq,
  output logic reqReady,
  output logic rspValid,
  output logic [asr_pkg::DATA_W-1:0] rspRdata,
  output logic retaining,
  // Memory pins
  output logic [asr_pkg::ADDR_W-1:0] word_address,
  output logic chipSel_n,
  output logic writeStrobe_n,
  output logic outGate_n,
  output logic low_byte_sel_n,
  output logic high_byte_sel_n,
  input wire logic [asr_pkg::DATA_W-1:0] shared_data_lines_in,
  output logic [asr_pkg::DATA_W-1:0] shared_data_lines_out,
  output logic [asr_pkg::DATA_W-1:0] shared_data_lines_oe_n
);
  import asr_pkg::*;

  // ==========================================================
  // State and next values
  asr_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_reqReady, next_rspValid, next_retaining;
  logic [DATA_W-1:0] next_rspRdata, next_dout, next_oe_n;
  logic [ADDR_W-1:0] next_addr;
  logic next_cs_n, next_we_n, next_og_n, next_lb_n, next_hb_n;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_reqReady = 1'b0;
    next_rspValid = 1'b0;
    next_retaining = retaining;
    next_rspRdata = rspRdata;
    next_dout = shared_data_lines_out;
    next_oe_n = shared_data_lines_oe_n;
    next_addr = word_address;
    next_cs_n = chipSel_n;
    next_we_n = writeStrobe_n;
    next_og_n = outGate_n;
    next_lb_n = low_byte_sel_n;
    next_hb_n = high_byte_sel_n;
    unique case (state)
      ASR_IDLE: begin
        next_reqReady = 1'b1;
        if (retainReq) begin
          // Deselect before supply drop
          next_cs_n = 1'b1;
          next_lb_n = 1'b1;
          next_hb_n = 1'b1;
          next_retaining = 1'b1;
          next_reqReady = 1'b0;
          next_state = ASR_RET;
        end else if (reqValid && reqReady && reqByteEn != 2'b00) begin
          next_reqReady = 1'b0;
          next_addr = reqAddr;
          next_cs_n = 1'b0;
          next_lb_n = ~reqByteEn[0];
          next_hb_n = ~reqByteEn[1];
          next_cnt = '0;
          if (reqWrite) begin
            // Output gate held off so device never drives
            next_og_n = 1'b1;
            next_we_n = 1'b0;
            next_dout = reqWdata;
            next_oe_n = '0;
            next_state = ASR_WR;
          end else begin
            next_og_n = 1'b0;
            next_state = ASR_RD;
          end
        end
      end
      ASR_RD: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(ACC_CYC - 1)) begin
          next_rspRdata = shared_data_lines_in;
          next_rspValid = 1'b1;
          next_cs_n = 1'b1;
          next_og_n = 1'b1;
          next_lb_n = 1'b1;
          next_hb_n = 1'b1;
          next_cnt = '0;
          next_state = ASR_GAP;
        end
      end
      ASR_WR: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(WP_CYC - 1)) begin
          // End write; address and data held through this edge
          next_we_n = 1'b1;
          next_cs_n = 1'b1;
          next_lb_n = 1'b1;
          next_hb_n = 1'b1;
          next_rspValid = 1'b1;
          next_cnt = '0;
          next_state = ASR_GAP;
        end
      end
      ASR_GAP: begin
        // Release bus and let device outputs fall off
        next_oe_n = '1;
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(HZ_CYC - 1)) begin
          next_cnt = '0;
          next_state = ASR_IDLE;
          next_reqReady = ~retainReq;
        end
      end
      ASR_RET: begin
        if (retainReq) begin
          next_cnt = '0;
        end else begin
          next_cnt = cnt + 1'b1;
          if (cnt == CNT_W'(REC_CYC - 1)) begin
            // Recovery wait done
            next_retaining = 1'b0;
            next_cnt = '0;
            next_state = ASR_IDLE;
          end
        end
      end
      default: next_state = ASR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ASR_IDLE;
      cnt <= '0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspRdata <= '0;
      retaining <= 1'b0;
      word_address <= '0;
      chipSel_n <= 1'b1;
      writeStrobe_n <= 1'b1;
      outGate_n <= 1'b1;
      low_byte_sel_n <= 1'b1;
      high_byte_sel_n <= 1'b1;
      shared_data_lines_out <= '0;
      shared_data_lines_oe_n <= '1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      reqReady <= next_reqReady;
      rspValid <= next_rspValid;
      rspRdata <= next_rspRdata;
      retaining <= next_retaining;
      word_address <= next_addr;
      chipSel_n <= next_cs_n;
      writeStrobe_n <= next_we_n;
      outGate_n <= next_og_n;
      low_byte_sel_n <= next_lb_n;
      high_byte_sel_n <= next_hb_n;
      shared_data_lines_out <= next_dout;
      shared_data_lines_oe_n <= next_oe_n;
    end
  end

  // ==========================================================
  // Assertions
  no_contention_a: assert property (@(posedge clk) disable iff (reset)
    !((shared_data_lines_oe_n != '1) && !outGate_n))
    else $error("host drives data while output gate active");
  wr_pulse_a: assert property (@(posedge clk) disable iff (reset)
    $fell(writeStrobe_n) |-> !writeStrobe_n [*2])
    else $error("write pulse shorter than 35 ns");
  addr_hold_a: assert property (@(posedge clk) disable iff (reset)
    !writeStrobe_n && !$fell(writeStrobe_n) |-> $stable(word_address))
    else $error("address moved during write");
  data_hold_a: assert property (@(posedge clk) disable iff (reset)
    !writeStrobe_n && !$fell(writeStrobe_n) |-> $stable(shared_data_lines_out))
    else $error("write data moved during write");
  wr_cs_a: assert property (@(posedge clk) disable iff (reset)
    !writeStrobe_n |-> !chipSel_n && !(low_byte_sel_n && high_byte_sel_n))
    else $error("write strobe without select");
  rd_time_a: assert property (@(posedge clk) disable iff (reset)
    $fell(outGate_n) |-> !outGate_n [*3] ##1 rspValid)
    else $error("read sampled too early or late");
  cyc_space_a: assert property (@(posedge clk) disable iff (reset)
    $rose(chipSel_n) |-> chipSel_n [*2])
    else $error("cycles spaced under 45 ns");
  retain_sel_a: assert property (@(posedge clk) disable iff (reset)
    retaining |-> chipSel_n)
    else $error("chip selected during retention");
endmodule

// file: logic/asr_pkg.sv
// Package of constants for the asynchronous SRAM host controller
package asr_pkg;
  // ==========================================================
  // Geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  // ==========================================================
  // Timing in ns (retention recovery in ms) and derived cycles at 40 MHz
  localparam int CLK_PS = 25000;
  localparam int T_CYCLE_NS = 45;
  localparam int T_WP_NS = 35;
  localparam int T_DW_NS = 25;
  localparam int T_ACC_NS = 45;
  localparam int T_HZ_NS = 18;
  localparam int T_OW_NS = 5;
  localparam int T_REC_MS = 5;
  localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS + 1;
  localparam int HZ_CYC = (T_HZ_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CYC_CYC = (T_CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int REC_CYC_DEF = T_REC_MS * 1000000 / (CLK_PS / 1000);
  localparam int CNT_W = 20;
  // ==========================================================
  // Controller states, Gray only on IDLE to RD, WR to GAP and GAP to IDLE
  typedef enum logic [2:0] {
    ASR_IDLE = 3'b000,
    ASR_RD = 3'b001,
    ASR_WR = 3'b011,
    ASR_GAP = 3'b010,
    ASR_RET = 3'b110
  } asr_state_e;
endpackage
